// ===== shared/lio_consts.vh
// constants for the lab i/o register bank: host addresses, counter
// commands, field positions and timing figures.
// assumes a byte-wide host bus with 16-bit addresses and one-cycle strobes.
`ifndef LIO_CONSTS_VH
`define LIO_CONSTS_VH
`define LIO_ADDR_AOUT1_LO 16'hc0b0
`define LIO_ADDR_AOUT1_HI 16'hc0b1
`define LIO_ADDR_AOUT2_LO 16'hc0b2
`define LIO_ADDR_AOUT2_HI 16'hc0b3
`define LIO_ADDR_DOUT_LO 16'hc0b4
`define LIO_ADDR_DOUT_HI 16'hc0b5
`define LIO_ADDR_CNT_DATA 16'hc0b6
`define LIO_ADDR_DIN 16'hc0b7
`define LIO_ADDR_CNT_CMD 16'hc0be
`define LIO_CMD_RESET 8'hff
`define LIO_CMD_PTR_FIRST 8'h01
`define LIO_CMD_MODE 8'h17
`define LIO_CMD_ARM 8'h7f
`define LIO_CMD_HOLD_A_LO 8'h12
`define LIO_CMD_HOLD_B_HI 8'h15
`define LIO_CFG_BYTES 5'h1e
`define LIO_CFG_CNT_LO 5'h02
`define LIO_CFG_CNT_HI 5'h03
`define LIO_CFG_BLK_LO 5'h04
`define LIO_CFG_BLK_HI 5'h05
`define LIO_RELAY_HI 11
`define LIO_RELAY_LO 8
`define LIO_SSR_HI 12
`define LIO_SSR_LO 11
`define LIO_MUX_HI 15
`define LIO_MUX_LO 13
`define LIO_TICK_MS 10
`define LIO_CLK_KHZ 10000
`define LIO_WORD_RST 16'h0000
`define LIO_BYTE_RST 8'h00
`endif

// ===== verilog/lio_bank.v
// lab i/o register bank: analog/digital output latches, live digital
// input port, integrating pulse counter with command/data ports and a
// sample fifo between the integrator and the holding registers.
// assumes sys_clk at 10 MHz, host strobes synchronous to sys_clk and
// all pin inputs asynchronous.
`timescale 1ns/1ns
`include "lio_consts.vh"

module lio_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // full-width copies first, then cut on purpose to the pointer widths
  localparam [31:0] FULL_CNT_W = DEPTH;
  localparam [31:0] LAST_W = DEPTH - 1;
  localparam [AW:0] FULL_CNT = FULL_CNT_W[AW:0];
  localparam [AW-1:0] LAST = LAST_W[AW-1:0];
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage only written, never reset; pointers guard validity
  always @(posedge sys_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // pointers wrap at depth, so depth need not be a power of two
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == LAST) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == LAST) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // lio_fifo

module lio_bank #(
  parameter TICK_CYCLES = `LIO_TICK_MS * `LIO_CLK_KHZ,
  parameter TICK_W = 17,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // host bus
  input wire [15:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  // analog output words
  output reg [15:0] aout_one_word,
  output reg [15:0] aout_two_word,
  // digital outputs and drivers
  output reg [15:0] digital_out_lines,
  output reg [7:0] drv_out,
  output reg drv_oe,
  output reg [3:0] relay_drv,
  output reg [1:0] ssr_drv,
  output reg [2:0] mux_sel,
  input wire drv_en_n,
  // digital inputs and pulse inputs
  input wire [5:0] digital_in_lines,
  input wire vf_pulse_a,
  input wire vf_pulse_b,
  // status
  output reg integrating
);
  localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
  localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_W[TICK_W-1:0];
  localparam [1:0] ST_OFF = 2'b00;
  localparam [1:0] ST_INTEG = 2'b01;
  localparam [1:0] ST_PUSH = 2'b10;
  localparam [1:0] ST_BLANK = 2'b11;

  // pin synchronisers
  reg [5:0] din_s1_q;
  reg [5:0] din_s2_q;
  reg [1:0] vf_s1_q;
  reg [1:0] vf_s2_q;
  reg [1:0] vf_s3_q;
  reg en_s1_q;
  reg en_s2_q;
  // counter configuration and pointers
  reg [7:0] cfg_q [0:`LIO_CFG_BYTES-1];
  reg [4:0] ptr_q;
  reg mode_wr_q;
  reg mode_byte_q;
  reg [15:0] mode_q;
  reg hold_sel_q;
  reg [1:0] hold_word_q;
  reg hold_byte_q;
  // integrator
  reg armed_q;
  reg [1:0] state_q;
  reg [TICK_W-1:0] tick_q;
  reg [15:0] dur_q;
  reg [31:0] cnt_a_q;
  reg [31:0] cnt_b_q;
  integer i;

  wire tick;
  wire [1:0] vf_rise;
  wire [15:0] count_len;
  wire [15:0] blank_len;
  wire fifo_in_ready;
  wire sample_ready;
  wire [63:0] hold_data;
  reg [15:0] hold_word;
  wire [7:0] hold_byte;
  wire [7:0] cfg_rd_byte;
  wire w_a1l, w_a1h, w_a2l, w_a2h, w_dol, w_doh, w_dat, w_din, w_cmd;
  wire r_dat, r_din;

  function lio_hit;
    input [15:0] addr;
    input [15:0] loc;
    begin
      lio_hit = (addr == loc);
    end
  endfunction

  // address decode for both strobes
  assign w_a1l = bus_wr & lio_hit(bus_addr, `LIO_ADDR_AOUT1_LO);
  assign w_a1h = bus_wr & lio_hit(bus_addr, `LIO_ADDR_AOUT1_HI);
  assign w_a2l = bus_wr & lio_hit(bus_addr, `LIO_ADDR_AOUT2_LO);
  assign w_a2h = bus_wr & lio_hit(bus_addr, `LIO_ADDR_AOUT2_HI);
  assign w_dol = bus_wr & lio_hit(bus_addr, `LIO_ADDR_DOUT_LO);
  assign w_doh = bus_wr & lio_hit(bus_addr, `LIO_ADDR_DOUT_HI);
  assign w_dat = bus_wr & lio_hit(bus_addr, `LIO_ADDR_CNT_DATA);
  assign w_din = bus_wr & lio_hit(bus_addr, `LIO_ADDR_DIN);
  assign w_cmd = bus_wr & lio_hit(bus_addr, `LIO_ADDR_CNT_CMD);
  assign r_dat = bus_rd & lio_hit(bus_addr, `LIO_ADDR_CNT_DATA);
  assign r_din = bus_rd & lio_hit(bus_addr, `LIO_ADDR_DIN);

  // two flops on every pin, a third on the pulse pins; edge detect reads only the second and third
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      din_s1_q <= 6'h00;
      din_s2_q <= 6'h00;
      vf_s1_q <= 2'h0;
      vf_s2_q <= 2'h0;
      vf_s3_q <= 2'h0;
      en_s1_q <= 1'b1;
      en_s2_q <= 1'b1;
    end
    else
    begin
      din_s1_q <= digital_in_lines;
      din_s2_q <= din_s1_q;
      vf_s1_q <= {vf_pulse_b, vf_pulse_a};
      vf_s2_q <= vf_s1_q;
      vf_s3_q <= vf_s2_q;
      en_s1_q <= drv_en_n;
      en_s2_q <= en_s1_q;
    end
  end
  assign vf_rise = vf_s2_q & ~vf_s3_q;

  // output latches keep their value until rewritten
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aout_one_word <= `LIO_WORD_RST;
      aout_two_word <= `LIO_WORD_RST;
      digital_out_lines <= `LIO_WORD_RST;
    end
    else
    begin
      // each byte lands in its half; the word is two's complement as is
      if (w_a1l)
        aout_one_word[7:0] <= bus_wdata;
      if (w_a1h)
        aout_one_word[15:8] <= bus_wdata;
      if (w_a2l)
        aout_two_word[7:0] <= bus_wdata;
      if (w_a2h)
        aout_two_word[15:8] <= bus_wdata;
      if (w_dol)
        digital_out_lines[7:0] <= bus_wdata;
      if (w_doh)
        digital_out_lines[15:8] <= bus_wdata;
    end
  end

  // driver copies follow the latches one cycle later
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      drv_out <= `LIO_BYTE_RST;
      drv_oe <= 1'b0;
      relay_drv <= 4'h0;
      ssr_drv <= 2'h0;
      mux_sel <= 3'h0;
    end
    else
    begin
      drv_out <= digital_out_lines[7:0];
      drv_oe <= ~en_s2_q;
      relay_drv <= digital_out_lines[`LIO_RELAY_HI:`LIO_RELAY_LO];
      ssr_drv <= digital_out_lines[`LIO_SSR_HI:`LIO_SSR_LO];
      mux_sel <= digital_out_lines[`LIO_MUX_HI:`LIO_MUX_LO];
    end
  end

  // durations in 10 ms units; zero acts as one unit
  assign count_len = {cfg_q[`LIO_CFG_CNT_HI], cfg_q[`LIO_CFG_CNT_LO]};
  assign blank_len = {cfg_q[`LIO_CFG_BLK_HI], cfg_q[`LIO_CFG_BLK_LO]};
  assign tick = (tick_q == TICK_LAST);

  // integrate, queue the sample, idle, repeat; a full fifo stalls here
  always @(posedge sys_clk)
  begin
    if (sys_rst || (w_cmd && bus_wdata == `LIO_CMD_RESET))
    begin
      state_q <= ST_OFF;
      tick_q <= {TICK_W{1'b0}};
      dur_q <= 16'h0000;
      cnt_a_q <= 32'h00000000;
      cnt_b_q <= 32'h00000000;
      integrating <= 1'b0;
    end
    else
    begin
      tick_q <= tick ? {TICK_W{1'b0}} : tick_q + 1'b1;
      integrating <= (state_q == ST_INTEG);
      case (state_q)
        ST_OFF:
        begin
          if (armed_q)
          begin
            state_q <= ST_INTEG;
            dur_q <= count_len;
            tick_q <= {TICK_W{1'b0}};
            cnt_a_q <= 32'h00000000;
            cnt_b_q <= 32'h00000000;
          end
        end
        ST_INTEG:
        begin
          cnt_a_q <= cnt_a_q + {31'h0, vf_rise[0]};
          cnt_b_q <= cnt_b_q + {31'h0, vf_rise[1]};
          if (tick)
          begin
            dur_q <= dur_q - 16'h0001;
            if (dur_q <= 16'h0001)
              state_q <= ST_PUSH;
          end
        end
        ST_PUSH:
        begin
          if (fifo_in_ready)
          begin
            state_q <= ST_BLANK;
            dur_q <= blank_len;
          end
        end
        ST_BLANK:
        begin
          if (tick)
          begin
            dur_q <= dur_q - 16'h0001;
            if (dur_q <= 16'h0001)
            begin
              state_q <= ST_INTEG;
              dur_q <= count_len;
              cnt_a_q <= 32'h00000000;
              cnt_b_q <= 32'h00000000;
            end
          end
        end
        default:
          state_q <= ST_OFF;
      endcase
    end
  end

  // head of the fifo is the holding register set; acknowledged by a write
  // to the input port, so an unread period is never overwritten
  lio_fifo #(
    .WIDTH(64),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(state_q == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data({cnt_b_q, cnt_a_q}),
    .out_valid(sample_ready),
    .out_ready(w_din),
    .out_data(hold_data)
  );

  // hold word chosen by command, byte chosen by read order
  always @*
  begin
    case (hold_word_q)
      2'h0: hold_word = hold_data[15:0];
      2'h1: hold_word = hold_data[31:16];
      2'h2: hold_word = hold_data[47:32];
      default: hold_word = hold_data[63:48];
    endcase
  end
  assign hold_byte = hold_byte_q ? hold_word[15:8] : hold_word[7:0];
  assign cfg_rd_byte = mode_wr_q ? (mode_byte_q ? mode_q[15:8] : mode_q[7:0]) :
                       cfg_q[ptr_q];

  // command port and data pointer
  always @(posedge sys_clk)
  begin
    if (sys_rst || (w_cmd && bus_wdata == `LIO_CMD_RESET))
    begin
      ptr_q <= 5'h00;
      mode_wr_q <= 1'b0;
      mode_byte_q <= 1'b0;
      mode_q <= `LIO_WORD_RST;
      hold_sel_q <= 1'b0;
      hold_word_q <= 2'h0;
      hold_byte_q <= 1'b0;
      armed_q <= 1'b0;
      for (i = 0; i < `LIO_CFG_BYTES; i = i + 1)
        cfg_q[i] <= `LIO_BYTE_RST;
    end
    else if (w_cmd)
    begin
      if (bus_wdata == `LIO_CMD_PTR_FIRST)
      begin
        ptr_q <= 5'h00;
        mode_wr_q <= 1'b0;
        hold_sel_q <= 1'b0;
      end
      else if (bus_wdata == `LIO_CMD_MODE)
      begin
        mode_wr_q <= 1'b1;
        mode_byte_q <= 1'b0;
        hold_sel_q <= 1'b0;
      end
      else if (bus_wdata == `LIO_CMD_ARM)
        armed_q <= 1'b1;
      else if (bus_wdata >= `LIO_CMD_HOLD_A_LO && bus_wdata <= `LIO_CMD_HOLD_B_HI)
      begin
        hold_sel_q <= 1'b1;
        hold_word_q <= bus_wdata[1:0] - 2'h2;
        hold_byte_q <= 1'b0;
      end
    end
    else if (w_dat)
    begin
      // writes land at the pointer, low byte first, then step on
      if (mode_wr_q)
      begin
        if (mode_byte_q)
          mode_q[15:8] <= bus_wdata;
        else
          mode_q[7:0] <= bus_wdata;
        mode_byte_q <= ~mode_byte_q;
      end
      else
      begin
        cfg_q[ptr_q] <= bus_wdata;
        ptr_q <= (ptr_q == `LIO_CFG_BYTES - 5'h01) ? 5'h00 : ptr_q + 5'h01;
      end
    end
    else if (r_dat)
    begin
      // a read flips the hold or mode byte if selected, else steps the pointer, which is why hosts pre-select
      if (hold_sel_q)
        hold_byte_q <= ~hold_byte_q;
      else if (mode_wr_q)
        mode_byte_q <= ~mode_byte_q;
      else
        ptr_q <= (ptr_q == `LIO_CFG_BYTES - 5'h01) ? 5'h00 : ptr_q + 5'h01;
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      bus_rdata <= `LIO_BYTE_RST;
    else if (r_din)
      bus_rdata <= {sample_ready, 1'b0, din_s2_q};
    else if (r_dat)
      bus_rdata <= hold_sel_q ? hold_byte : cfg_rd_byte;
    else if (bus_rd)
      bus_rdata <= `LIO_BYTE_RST;
  end
endmodule // lio_bank

// ===== bench/lio_pulse_src.sv
// pulse source standing in for the two frequency converters.
// assumes the bank counts rising edges behind a short input path.
`timescale 1ns/1ns
module lio_pulse_src (
  // clock
  input wire sys_clk,
  // pulse pins
  output logic vf_pulse_a,
  output logic vf_pulse_b
);
  initial
  begin
    vf_pulse_a = 1'b0;
    vf_pulse_b = 1'b0;
  end

  // six clocks a pulse, so no edge is lost in the synchroniser
  task burst(input int na, input int nb);
    for (int i = 0; i < na || i < nb; i++)
    begin
      @(posedge sys_clk);
      vf_pulse_a <= (i < na);
      vf_pulse_b <= (i < nb);
      repeat (3) @(posedge sys_clk);
      vf_pulse_a <= 1'b0;
      vf_pulse_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule // lio_pulse_src

// ===== bench/lio_bank_assertions.sv
// checker for the lab i/o bank, watching its top ports only.
// assumes one clock and a synchronous active high reset.
`timescale 1ns/1ns
`include "lio_consts.vh"
module lio_bank_chk (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // host bus
  input wire [15:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  // outputs and pins
  input wire [15:0] aout_one_word,
  input wire [15:0] digital_out_lines,
  input wire [7:0] drv_out,
  input wire drv_oe,
  input wire [3:0] relay_drv,
  input wire [1:0] ssr_drv,
  input wire [2:0] mux_sel,
  input wire drv_en_n,
  input wire [5:0] digital_in_lines
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [5:0] din_q;
  logic [2:0] din_st;

  // input age, so live reads are judged only once past the synchroniser
  always @(posedge sys_clk)
  begin
    din_q <= digital_in_lines;
    if (sys_rst || din_q != digital_in_lines)
      din_st <= 3'h0;
    else if (din_st != 3'h7)
      din_st <= din_st + 3'h1;
  end

  property p_aout_lo;
    bus_wr && bus_addr == `LIO_ADDR_AOUT1_LO |=> aout_one_word[7:0] == $past(bus_wdata);
  endproperty
  a_aout_lo: assert property (p_aout_lo) else $error("analog low byte not loaded");
  property p_dout_lo;
    bus_wr && bus_addr == `LIO_ADDR_DOUT_LO |=> digital_out_lines[7:0] == $past(bus_wdata);
  endproperty
  a_dout_lo: assert property (p_dout_lo) else $error("output low byte not loaded");
  property p_dout_hold;
    !(bus_wr && bus_addr == `LIO_ADDR_DOUT_LO) && !sys_rst |=> $stable(digital_out_lines[7:0]);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("output byte moved");
  property p_relay;
    relay_drv == $past(digital_out_lines[11:8]) && ssr_drv == $past(digital_out_lines[12:11]);
  endproperty
  a_relay: assert property (p_relay) else $error("relay or switch copy wrong");
  property p_mux;
    mux_sel == $past(digital_out_lines[15:13]);
  endproperty
  a_mux: assert property (p_mux) else $error("mux select wrong");
  property p_drv;
    drv_out == $past(digital_out_lines[7:0]);
  endproperty
  a_drv: assert property (p_drv) else $error("driver copy wrong");
  property p_drv_oe;
    drv_en_n [*5] |-> !drv_oe;
  endproperty
  a_drv_oe: assert property (p_drv_oe) else $error("driver enabled while off");
  property p_din;
    bus_rd && bus_addr == `LIO_ADDR_DIN && din_st >= 3'h3
      |=> bus_rdata[6:0] == {1'b0, $past(digital_in_lines, 3)}; // two sync flops
  endproperty
  a_din: assert property (p_din) else $error("input byte not live");
  property p_rd_hold;
    !bus_rd && !sys_rst |=> $stable(bus_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule // lio_bank_chk

// ===== bench/testbench.sv
// self-checking bench for the lab i/o bank: outputs, live inputs,
// counter set-up, sample read-out and the sample fifo.
// assumes the bank's header on the include path.
`timescale 1ns/1ns
`include "lio_consts.vh"
module testbench;
  logic sys_clk, sys_rst, bus_wr, bus_rd, drv_oe, drv_en_n;
  logic vf_pulse_a, vf_pulse_b, integrating;
  logic [15:0] bus_addr, aout_one_word, aout_two_word, digital_out_lines, w;
  logic [7:0] bus_wdata, bus_rdata, drv_out, rd_v, lo, hi;
  logic [3:0] relay_drv;
  logic [1:0] ssr_drv;
  logic [2:0] mux_sel;
  logic [5:0] digital_in_lines;
  int err_total = 0;
  int tests_run = 0;
  int j, k, na, nb;
  int unsigned seed_v;

  // a four-clock tick keeps each period short
  lio_bank #(
    .TICK_CYCLES(4)
  ) dut_u (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .aout_one_word(aout_one_word),
    .aout_two_word(aout_two_word),
    .digital_out_lines(digital_out_lines),
    .drv_out(drv_out),
    .drv_oe(drv_oe),
    .relay_drv(relay_drv),
    .ssr_drv(ssr_drv),
    .mux_sel(mux_sel),
    .drv_en_n(drv_en_n),
    .digital_in_lines(digital_in_lines),
    .vf_pulse_a(vf_pulse_a),
    .vf_pulse_b(vf_pulse_b),
    .integrating(integrating)
  );
  lio_pulse_src pulse_u (
    .sys_clk(sys_clk),
    .vf_pulse_a(vf_pulse_a),
    .vf_pulse_b(vf_pulse_b)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task results();
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  task rd(input logic [15:0] a);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 rd_v = bus_rdata;
  endtask

  // bounded poll; a lost sample shows up in the flag check after it
  task wait_ready();
    rd(`LIO_ADDR_DIN);
    for (k = 0; k < 1000 && rd_v[7] !== 1'b1; k++)
      rd(`LIO_ADDR_DIN);
  endtask

  // durations sit in bytes two to five, low byte first
  function automatic logic [7:0] cfg_byte(int i, logic [15:0] len, logic [15:0] idle);
    case (i)
      2: return len[7:0];
      3: return len[15:8];
      4: return idle[7:0];
      5: return idle[15:8];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [8:0] exp_drv(logic [7:0] h);
    return {h[7:5], h[4:3], h[3:0]};
  endfunction

  task init_ctr(input logic [15:0] len, input logic [15:0] idle);
    wr(`LIO_ADDR_CNT_CMD, `LIO_CMD_RESET);
    wr(`LIO_ADDR_CNT_CMD, `LIO_CMD_PTR_FIRST);
    for (int i = 0; i < 30; i++)
      wr(`LIO_ADDR_CNT_DATA, cfg_byte(i, len, idle));
    // pointer wrapped to zero; reads step it, so the third read is byte two
    repeat (3) rd(`LIO_ADDR_CNT_DATA);
    check(rd_v, len[7:0]);
    wr(`LIO_ADDR_CNT_CMD, `LIO_CMD_MODE);
    wr(`LIO_ADDR_CNT_DATA, 8'h00);
    wr(`LIO_ADDR_CNT_DATA, 8'h90);
    wr(`LIO_ADDR_CNT_CMD, `LIO_CMD_ARM);
  endtask

  task rd_word(input logic [7:0] cmd);
    wr(`LIO_ADDR_CNT_CMD, cmd);
    rd(`LIO_ADDR_CNT_DATA);
    lo = rd_v;
    rd(`LIO_ADDR_CNT_DATA);
    w = {rd_v, lo};
  endtask

  initial
  begin
    sys_rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    drv_en_n = 1'b0;
    digital_in_lines = 6'h00;
    seed_v = $urandom(42);
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 check(aout_one_word | aout_two_word | digital_out_lines, 16'h0000);
    // both full scales first, then random words
    for (j = 0; j < 8; j++)
    begin
      w = (j == 0) ? 16'h7fff : (j == 1) ? 16'h8000 : 16'($urandom);
      wr(`LIO_ADDR_AOUT1_LO, w[7:0]);
      wr(`LIO_ADDR_AOUT1_HI, w[15:8]);
      wr(`LIO_ADDR_AOUT2_LO, ~w[7:0]);
      wr(`LIO_ADDR_AOUT2_HI, ~w[15:8]);
      @(posedge sys_clk);
      #1 check(aout_one_word, w);
      check(aout_two_word, ~w);
    end
    wr(`LIO_ADDR_AOUT1_LO, 8'h5a);
    @(posedge sys_clk);
    #1 check(aout_one_word, {w[15:8], 8'h5a});
    rd(`LIO_ADDR_AOUT1_LO);
    check(rd_v, 8'h00);
    for (j = 0; j < 8; j++)
    begin
      lo = (j == 0) ? 8'hff : 8'($urandom);
      hi = (j == 1) ? 8'hff : 8'($urandom);
      wr(`LIO_ADDR_DOUT_LO, lo);
      wr(`LIO_ADDR_DOUT_HI, hi);
      repeat (2) @(posedge sys_clk);
      #1 check(digital_out_lines, {hi, lo});
      check(drv_out, lo);
      check({mux_sel, ssr_drv, relay_drv}, exp_drv(hi));
    end
    // an unmapped place neither answers nor disturbs the latches
    wr(16'hc0b8, 8'h00);
    rd(16'hc0b8);
    check(rd_v, 8'h00);
    check(digital_out_lines, {hi, lo});
    for (j = 0; j < 2; j++)
    begin
      @(posedge sys_clk);
      drv_en_n <= ~j[0];
      repeat (5) @(posedge sys_clk);
      #1 check(drv_oe, j[0]);
    end
    // walking one checks the bit order of the live input byte
    for (j = 0; j < 6; j++)
    begin
      @(posedge sys_clk);
      digital_in_lines <= 6'h01 << j;
      repeat (4) @(posedge sys_clk);
      rd(`LIO_ADDR_DIN);
      check(rd_v, {2'b00, 6'h01 << j});
    end
    init_ctr(16'd40, 16'd150);
    for (k = 0; k < 20 && integrating !== 1'b1; k++)
      @(posedge sys_clk);
    #1 check(integrating, 1'b1);
    na = 1 + $urandom % 20;
    nb = 1 + $urandom % 20;
    pulse_u.burst(na, nb);
    wait_ready();
    check(rd_v[7], 1'b1);
    rd_word(`LIO_CMD_HOLD_A_LO);
    check(w, 16'(na));
    rd_word(8'h13);
    check(w, 16'h0000);
    rd_word(8'h14);
    check(w, 16'(nb));
    rd_word(`LIO_CMD_HOLD_B_HI);
    check(w, 16'h0000);
    wr(`LIO_ADDR_DIN, 8'h00);
    rd(`LIO_ADDR_DIN);
    check(rd_v[7], 1'b0);
    // the next period saw no pulses at all
    wait_ready();
    check(rd_v[7], 1'b1);
    rd_word(`LIO_CMD_HOLD_A_LO);
    check(w, 16'h0000);
    wr(`LIO_ADDR_DIN, 8'h00);
    // shortest periods fill the fifo; a counter reset then stops the feed
    init_ctr(16'd1, 16'd1);
    repeat (800) @(posedge sys_clk);
    wr(`LIO_ADDR_CNT_CMD, `LIO_CMD_RESET);
    for (j = 0; j < 32; j++)
    begin
      rd(`LIO_ADDR_DIN);
      check(rd_v[7], 1'b1);
      wr(`LIO_ADDR_DIN, 8'h00);
    end
    rd(`LIO_ADDR_DIN);
    check(rd_v[7], 1'b0);
    results();
  end

  // far above the few thousand clocks the tests take
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    results();
  end
endmodule // testbench

bind lio_bank lio_bank_chk chk_u (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_wr(bus_wr),
  .bus_rd(bus_rd),
  .bus_rdata(bus_rdata),
  .aout_one_word(aout_one_word),
  .digital_out_lines(digital_out_lines),
  .drv_out(drv_out),
  .drv_oe(drv_oe),
  .relay_drv(relay_drv),
  .ssr_drv(ssr_drv),
  .mux_sel(mux_sel),
  .drv_en_n(drv_en_n),
  .digital_in_lines(digital_in_lines)
);
